// file: verilog/ucs_pkg.sv
// Constants, field layouts and carrier types for the user curve sweep
// sequencer. Assumes a 200 MHz system clock and a plain register port.
`default_nettype none

package ucs_pkg;

	// Table and value widths
	localparam int              NumPoints  = 100;
	localparam int              IdxW       = 7;
	localparam int              ValW       = 16;
	localparam logic [IdxW-1:0] IdxFirst   = 7'h01;
	localparam logic [IdxW-1:0] IdxLast    = 7'h64;
	localparam logic [ValW-1:0] ValMax     = 16'hffff;
	localparam logic [ValW-1:0] ValZero    = 16'h0000;

	// Dwell timing: one millisecond tick derived from the clock rate
	localparam int              ClockHz    = 200_000_000;
	localparam int              TickMs     = 1;
	localparam int              TickCycles = ClockHz / 1000 * TickMs;
	localparam int              TickW      = 18;
	localparam logic [ValW-1:0] DwellMaxMs = 16'hea60;  // 60000 ms

	// Register indices (byte address = index, plain port)
	localparam int              AddrW      = 8;
	localparam logic [7:0] RegCtrl     = 8'h00;  // W: go/stop/load pulses
	localparam logic [7:0] RegStatus   = 8'h01;  // R: state and flags
	localparam logic [7:0] RegStart    = 8'h02;
	localparam logic [7:0] RegEnd      = 8'h03;
	localparam logic [7:0] RegDwell    = 8'h04;
	localparam logic [7:0] RegRepeat   = 8'h05;
	localparam logic [7:0] RegPoint    = 8'h06;  // W: write point idx
	localparam logic [7:0] RegPointVal = 8'h07;  // W: value, writes point
	localparam logic [7:0] RegLoadCnt  = 8'h08;  // R: bulk points seen
	localparam logic [7:0] RegPeakU    = 8'h09;
	localparam logic [7:0] RegPeakI    = 8'h0a;
	localparam logic [7:0] RegPeakP    = 8'h0b;
	localparam logic [7:0] RegResIdx   = 8'h0c;  // W: result read index
	localparam logic [7:0] RegResU     = 8'h0d;
	localparam logic [7:0] RegResI     = 8'h0e;
	localparam logic [7:0] RegResP     = 8'h0f;
	localparam logic [7:0] RegPassCnt  = 8'h10;  // R: repetitions started

	// Control bit positions
	localparam int CtlGo      = 0;
	localparam int CtlStop    = 1;
	localparam int CtlLoadBeg = 2;  // begin bulk load
	localparam int CtlLoadEnd = 3;  // commit bulk load

	// Sweep states, one-hot
	typedef enum logic [3:0] {
		StIdle  = 4'h1,
		StDwell = 4'h2,
		StPause = 4'h4,
		StDone  = 4'h8
	} ucs_state_e;

	// One measured result set
	typedef struct packed {
		logic [ValW-1:0] volt;
		logic [ValW-1:0] curr;
		logic [ValW-1:0] pwr;
	} ucs_meas_s;

	// Set values driven to the power stage
	typedef struct packed {
		logic [ValW-1:0] volt;
		logic [ValW-1:0] curr;
		logic [ValW-1:0] pwr;
	} ucs_setp_s;

endpackage : ucs_pkg

`default_nettype wire

// file: verilog/ucs_sequencer.sv
// User curve sweep sequencer: steps a voltage set point through a table.
// Assumes measurements arrive synchronous to clock from the power stage
// and that software drives the register port one strobe at a time.
//
// Decided for this implementation: the strobed register port and the address map.
`default_nettype none

module ucs_sequencer
	import ucs_pkg::*;
#(
	// Cycles per millisecond tick; must fit TickW, a bench may shorten it
	parameter int TickLen = TickCycles
)
(
	// Clock and reset
	input  wire  logic             clock,
	input  wire  logic             reset,
	// Register port
	input  wire  logic [AddrW-1:0] regAddr,
	input  wire  logic [ValW-1:0]  regWrData,
	input  wire  logic             regWrite,
	input  wire  logic             regRead,
	output var   logic [ValW-1:0]  regRdData,
	// Power stage side
	input  wire  ucs_meas_s        measIn,
	input  wire  logic             remoteStandby,
	input  wire  logic             resistanceMode,
	output var   ucs_setp_s        setPoint,
	output var   logic             dcInputOn,
	output var   logic             userCurveMode
);

	////////////////////////////////////////////////////////////////////////
	// Storage and state

	logic [ValW-1:0] curveTable [NumPoints];  // Voltage per point
	ucs_meas_s       resultTable [NumPoints];  // Last measurement per point
	ucs_state_e      state_q;                  // Sweep state
	logic [IdxW-1:0] startIdx_q;               // 1-based
	logic [IdxW-1:0] endIdx_q;                 // 1-based
	logic [ValW-1:0] dwellMs_q;                // Dwell per point
	logic [ValW-1:0] repeat_q;                 // Extra passes
	logic [ValW-1:0] passCnt_q;                // Repetitions started this run
	logic [IdxW-1:0] curIdx_q;                 // Current point, 1-based
	logic [TickW-1:0] tick_q;                  // Cycle count toward 1 ms
	logic [ValW-1:0] msCnt_q;                  // Ms spent at this point
	logic [IdxW-1:0] ptSel_q;                  // Point write index
	logic [IdxW-1:0] resSel_q;                 // Result read index
	logic            loading_q;                // Bulk load open
	logic [IdxW-1:0] loadCnt_q;                // Points written in load
	logic [ValW-1:0] stage [NumPoints];        // Bulk load staging
	logic            refused_q;                // Last start refused
	ucs_meas_s       peak_q;                   // Highest power so far

	// Decoded strobes
	logic wrCtrl;
	logic wrPtVal;
	logic goReq;
	logic stopReq;
	logic dwellEnd;
	logic lastPoint;
	logic running;

	// Address match helper, used by every write decode below
	function automatic logic hit(input logic [AddrW-1:0] a,
		input logic [7:0] r);
		return a == r;
	endfunction

	// Map a 1-based index outside the legal range to the first point
	function automatic logic [IdxW-1:0] clampIdx(input logic [ValW-1:0] v);
		if (v[IdxW-1:0] < IdxFirst || v > {9'h000, IdxLast})
			return IdxFirst;
		return v[IdxW-1:0];
	endfunction

	assign wrCtrl   = regWrite && hit(regAddr, RegCtrl);
	assign wrPtVal  = regWrite && hit(regAddr, RegPointVal);
	assign goReq    = wrCtrl && regWrData[CtlGo];
	assign stopReq  = wrCtrl && regWrData[CtlStop];
	assign running  = (state_q == StDwell) || (state_q == StPause);
	// Dwell over once the programmed number of ms has elapsed
	assign dwellEnd = (tick_q == TickW'(TickLen - 1))
		&& (msCnt_q + 16'h0001 >= dwellMs_q);
	assign lastPoint = curIdx_q == endIdx_q;

	////////////////////////////////////////////////////////////////////////
	// Configuration registers

	// Indices, dwell and repeat; all but the result read index frozen while a run is live
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			startIdx_q <= IdxFirst;
			endIdx_q   <= IdxLast;
			dwellMs_q  <= DwellMaxMs;
			repeat_q   <= ValZero;
			ptSel_q    <= IdxFirst;
			resSel_q   <= IdxFirst;
		end else if (regWrite && !running) begin
			if (hit(regAddr, RegStart))
				startIdx_q <= clampIdx(regWrData);
			if (hit(regAddr, RegEnd))
				endIdx_q <= clampIdx(regWrData);
			if (hit(regAddr, RegDwell))
				// Above the ceiling saturates; zero would never dwell
				dwellMs_q <= (regWrData > DwellMaxMs) ? DwellMaxMs :
					(regWrData == ValZero ? 16'h0001 : regWrData);
			if (hit(regAddr, RegRepeat))
				repeat_q <= regWrData;
			if (hit(regAddr, RegPoint))
				ptSel_q <= clampIdx(regWrData);
			if (hit(regAddr, RegResIdx))
				resSel_q <= clampIdx(regWrData);
		end else if (regWrite && hit(regAddr, RegResIdx)) begin
			resSel_q <= clampIdx(regWrData);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Curve table and bulk load

	// Bulk load bookkeeping: count points, commit only when all arrive
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			loading_q <= 1'b0;
			loadCnt_q <= '0;
		end else if (wrCtrl && regWrData[CtlLoadBeg] && !running) begin
			loading_q <= 1'b1;
			loadCnt_q <= '0;
		end else if (wrCtrl && regWrData[CtlLoadEnd]) begin
			loading_q <= 1'b0;
		end else if (loading_q && wrPtVal && loadCnt_q != IdxLast) begin
			loadCnt_q <= loadCnt_q + 7'h01;
		end
	end

	// Table write: single point, or commit of a complete bulk load.
	// Start and end indices are untouched by a load.
	generate
		for (genvar p = 0; p < NumPoints; p++) begin : gTable
			always_ff @(posedge clock or posedge reset) begin
				if (reset) begin
					curveTable[p] <= ValZero;
					stage[p]      <= ValZero;
				end else begin
					if (loading_q && wrPtVal && loadCnt_q == IdxW'(p))
						stage[p] <= regWrData;
					if (wrCtrl && regWrData[CtlLoadEnd] && loading_q
						&& loadCnt_q == IdxLast && !running)
						curveTable[p] <= stage[p];
					else if (!loading_q && wrPtVal && !running
						&& ptSel_q == IdxW'(p + 1))
						curveTable[p] <= regWrData;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Sweep sequencer

	// Run state, point walk and pass count
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			state_q   <= StIdle;
			curIdx_q  <= IdxFirst;
			passCnt_q <= ValZero;
			tick_q    <= '0;
			msCnt_q   <= ValZero;
			refused_q <= 1'b0;
		end else begin
			unique case (state_q)
				StIdle, StDone: begin
					if (goReq && resistanceMode) begin
						refused_q <= 1'b1;
					end else if (goReq && !loading_q) begin
						refused_q <= 1'b0;
						state_q   <= StDwell;
						curIdx_q  <= startIdx_q;
						passCnt_q <= ValZero;
						tick_q    <= '0;
						msCnt_q   <= ValZero;
					end
				end
				StDwell: begin
					if (stopReq) begin
						state_q <= StDone;
					end else if (remoteStandby) begin
						state_q <= StPause;
					end else if (dwellEnd) begin
						tick_q  <= '0;
						msCnt_q <= ValZero;
						if (!lastPoint) begin
							curIdx_q <= curIdx_q + 7'h01;
						end else if (passCnt_q < repeat_q) begin
							// Next repetition restarts at start index
							passCnt_q <= passCnt_q + 16'h0001;
							curIdx_q  <= startIdx_q;
						end else begin
							state_q <= StDone;
						end
					end else if (tick_q == TickW'(TickLen - 1)) begin
						tick_q  <= '0;
						msCnt_q <= msCnt_q + 16'h0001;
					end else begin
						tick_q <= tick_q + 18'h00001;
					end
				end
				StPause: begin
					// Dwell timer holds; resume where it stood
					if (stopReq)
						state_q <= StDone;
					else if (!remoteStandby)
						state_q <= StDwell;
				end
				default: state_q <= StIdle;
			endcase
		end
	end

	// End index below start makes the pass run on past point 100 and wrap round to the end point
	// because the walk stops on a match only; limitation kept simple.

	////////////////////////////////////////////////////////////////////////
	// Results and peak point

	// Latest measurement of each point overwrites its result set
	generate
		for (genvar r = 0; r < NumPoints; r++) begin : gResult
			always_ff @(posedge clock or posedge reset) begin
				if (reset)
					resultTable[r] <= '0;
				else if (state_q == StDwell && dwellEnd
					&& curIdx_q == IdxW'(r + 1))
					resultTable[r] <= measIn;
			end
		end
	endgenerate

	// Peak tracked over the run; cleared at start
	always_ff @(posedge clock or posedge reset) begin
		if (reset)
			peak_q <= '0;
		else if (goReq && !resistanceMode && !loading_q && !running)
			peak_q <= '0;
		else if (state_q == StDwell && dwellEnd
			&& measIn.pwr > peak_q.pwr)
			peak_q <= measIn;
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs to the power stage

	// Voltage follows the table; current and power held at maximum
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			setPoint      <= '0;
			dcInputOn     <= 1'b0;
			userCurveMode <= 1'b0;
		end else begin
			setPoint.volt <= curveTable[curIdx_q - 7'h01];
			setPoint.curr <= ValMax;
			setPoint.pwr  <= ValMax;
			// DC input only on while dwelling; off on stop or finish
			dcInputOn     <= (state_q == StDwell) && !remoteStandby;
			userCurveMode <= running;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register read port

	// Read data one cycle after the strobe; zero otherwise
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			regRdData <= ValZero;
		end else if (!regRead) begin
			regRdData <= ValZero;
		end else begin
			unique case (regAddr)
				RegStatus:  regRdData <= {10'h000, refused_q, loading_q,
					state_q};
				RegStart:   regRdData <= {9'h000, startIdx_q};
				RegEnd:     regRdData <= {9'h000, endIdx_q};
				RegDwell:   regRdData <= dwellMs_q;
				RegRepeat:  regRdData <= repeat_q;
				RegLoadCnt: regRdData <= {9'h000, loadCnt_q};
				RegPeakU:   regRdData <= peak_q.volt;
				RegPeakI:   regRdData <= peak_q.curr;
				RegPeakP:   regRdData <= peak_q.pwr;
				// All 100 sets are exported whatever start and end
				RegResU:    regRdData <= resultTable[resSel_q - 7'h01].volt;
				RegResI:    regRdData <= resultTable[resSel_q - 7'h01].curr;
				RegResP:    regRdData <= resultTable[resSel_q - 7'h01].pwr;
				RegPassCnt: regRdData <= passCnt_q;
				default:    regRdData <= ValZero;
			endcase
		end
	end

endmodule // ucs_sequencer

`default_nettype wire

// file: test/ucs_source_model.sv
// Source under test for the sweep sequencer: a panel that follows the
// voltage set value. Assumes the sequencer's clock and reset.
`default_nettype none

module ucs_source_model
	import ucs_pkg::*;
#(
	parameter logic [ValW-1:0] SrcCurr = 16'h0010
)
(
	// Clock and reset
	input  wire logic      clock,
	input  wire logic      reset,
	// Drive from the power stage
	input  wire ucs_setp_s setPoint,
	input  wire logic      dcInputOn,
	// Measured values back
	output var  ucs_meas_s measIn
);
	timeunit 1ns;
	timeprecision 100ps;

	// Current flows only while the input is on; power is scaled to volts
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			measIn <= '0;
		end else begin
			measIn.volt <= setPoint.volt;
			measIn.curr <= dcInputOn ? SrcCurr : ValZero;
			measIn.pwr  <= dcInputOn ? setPoint.volt : ValZero;
		end
	end
endmodule // ucs_source_model

`default_nettype wire

// file: test/ucs_sequencer_asserts.sv
// Port checker for the sweep sequencer.
// Assumes one clock domain and an async active-high reset.
`default_nettype none

module ucs_sequencer_asserts
	import ucs_pkg::*;
#(
	// Cycles per millisecond tick, as the bound design uses
	parameter int TickLen = TickCycles
)
(
	// Clock and reset
	input wire logic             clock,
	input wire logic             reset,
	// Register port
	input wire logic [AddrW-1:0] regAddr,
	input wire logic [ValW-1:0]  regWrData,
	input wire logic             regWrite,
	input wire logic             regRead,
	input wire logic [ValW-1:0]  regRdData,
	// Power stage side
	input wire ucs_meas_s        measIn,
	input wire logic             remoteStandby,
	input wire logic             resistanceMode,
	input wire ucs_setp_s        setPoint,
	input wire logic             dcInputOn,
	input wire logic             userCurveMode
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clock); endclocking
	default disable iff (reset);

	// Control write decode
	logic ctlWr;
	assign ctlWr = regWrite && (regAddr == RegCtrl);

	////////////////////////////////////////////////////////////////////
	// Dwell cycles since the voltage set value last moved
	logic [19:0] holdCnt_q;
	always_ff @(posedge clock or posedge reset) begin
		if (reset)
			holdCnt_q <= '0;
		else if ($changed(setPoint.volt))
			holdCnt_q <= '0;
		else if (dcInputOn)
			holdCnt_q <= holdCnt_q + 20'h1;
	end

	////////////////////////////////////////////////////////////////////
	setp_max_a: assert property (!$past(reset) |->
		setPoint.curr == ValMax && setPoint.pwr == ValMax)
		else $error("current or power set value not maximum");
	standby_off_a: assert property (remoteStandby |=> !dcInputOn)
		else $error("input on while standby held");
	pause_hold_a: assert property (userCurveMode && !dcInputOn &&
		$past(userCurveMode) && !$past(dcInputOn) |-> $stable(setPoint.volt))
		else $error("set value moved while paused");
	resume_a: assert property ($fell(remoteStandby) && userCurveMode &&
		!regWrite |-> ##[1:2] dcInputOn)
		else $error("sweep did not resume");
	on_in_run_a: assert property (dcInputOn |-> userCurveMode)
		else $error("input on outside a run");
	stop_off_a: assert property (ctlWr && regWrData[CtlStop] |->
		##[1:2] (!dcInputOn && !userCurveMode))
		else $error("stop left input on");
	refuse_r_a: assert property (ctlWr && regWrData[CtlGo] &&
		resistanceMode && !userCurveMode |=> !userCurveMode)
		else $error("sweep started in resistance mode");
	dwell_len_a: assert property ($changed(setPoint.volt) &&
		userCurveMode && $past(userCurveMode) |->
		holdCnt_q >= 20'(TickLen - 2))
		else $error("point left before its dwell");
endmodule // ucs_sequencer_asserts

`default_nettype wire

// file: test/tb_ucs_sequencer.sv
// Self-checking bench for the sweep sequencer with a source model.
// Assumes a 200 MHz clock; the ms tick is shortened to TickSim cycles.
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin \
	err_total++; $display("FAIL %s exp %h got %h", nm, ex, got); end end

module tb_ucs_sequencer;
	import ucs_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;

	// Design connections
	logic             clock = 1'b0;
	logic             reset = 1'b1;
	logic [AddrW-1:0] regAddr = '0;
	logic [ValW-1:0]  regWrData = '0;
	logic             regWrite = 1'b0;
	logic             regRead = 1'b0;
	logic [ValW-1:0]  regRdData;
	ucs_meas_s        measIn;
	logic             remoteStandby = 1'b0;
	logic             resistanceMode = 1'b0;
	ucs_setp_s        setPoint;
	logic             dcInputOn;
	logic             userCurveMode;
	int               err_total = 0;
	int               check_count = 0;
	logic [15:0]      v;
	// Short tick keeps a full sweep to a few hundred cycles
	localparam int    TickSim = 200;

	always #2.5 clock = ~clock;

	ucs_sequencer #(.TickLen(TickSim)) u_ucs_sequencer (.clock, .reset,
		.regAddr, .regWrData, .regWrite, .regRead, .regRdData, .measIn,
		.remoteStandby, .resistanceMode, .setPoint, .dcInputOn,
		.userCurveMode);
	ucs_source_model u_ucs_source_model (.clock, .reset, .setPoint,
		.dcInputOn, .measIn);

	////////////////////////////////////////////////////////////////////
	// Register port: one-cycle strobes, read data the cycle after
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clock);
		regWrite <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clock);
		regWrite <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge clock);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge clock);
		regRead <= 1'b0;
		#1 d = regRdData;
	endtask
	task automatic rdc(input string nm, input logic [7:0] a,
		input logic [15:0] ex);
		logic [15:0] d;
		rd(a, d);
		`CHK(nm, ex, d)
	endtask
	// Start, look at the first set value, then stop
	task automatic go_stop(input string nm, input logic [15:0] ex);
		wr(RegCtrl, 16'h0001);
		repeat (3) @(posedge clock);
		#1 `CHK(nm, ex, setPoint.volt)
		wr(RegCtrl, 16'h0002);
		repeat (2) @(posedge clock);
		#1 `CHK("stop dc", 1'b0, dcInputOn)
	endtask

	////////////////////////////////////////////////////////////////////
	task automatic test_idle();
		rdc("status", RegStatus, 16'h0001);
		`CHK("curr max", ValMax, setPoint.curr)
		`CHK("pwr max", ValMax, setPoint.pwr)
		rdc("unmapped", 8'h3f, 16'h0000);
		@(posedge clock);
		resistanceMode <= 1'b1;
		wr(RegCtrl, 16'h0001);
		rd(RegStatus, v);
		`CHK("refused", 16'h0021, v & 16'h002f)
		@(posedge clock);
		resistanceMode <= 1'b0;
		$display("test_idle done");
	endtask

	// Points 5 and 6 twice, a standby pause inside the first dwell
	task automatic test_sweep();
		wr(RegStart, 16'h0005);
		wr(RegEnd, 16'h0006);
		wr(RegDwell, 16'h0001);
		wr(RegRepeat, 16'h0001);
		wr(RegPoint, 16'h0005);
		wr(RegPointVal, 16'h04d2);
		wr(RegCtrl, 16'h0001);
		repeat (TickSim / 4) @(posedge clock);
		remoteStandby <= 1'b1;
		rd(RegStatus, v);
		`CHK("pause", 16'h0004, v & 16'h000f)
		@(posedge clock);
		remoteStandby <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			repeat (i == 0 ? TickSim / 4 : TickSim) @(posedge clock);
			#1 `CHK("volt", i[0] ? ValZero : 16'h04d2, setPoint.volt)
			`CHK("dc on", 1'b1, dcInputOn)
		end
		for (int n = 0; n < TickSim && userCurveMode; n++)
			@(posedge clock);
		#1 `CHK("end dc", 1'b0, dcInputOn)
		// One repetition counted after the first pass
		rdc("passes", RegPassCnt, 16'h0001);
		rdc("peak U", RegPeakU, 16'h04d2);
		rdc("peak I", RegPeakI, 16'h0010);
		rdc("peak P", RegPeakP, 16'h04d2);
		wr(RegResIdx, 16'h0006);
		rdc("res6 I", RegResI, 16'h0010);
		rdc("res6 P", RegResP, 16'h0000);
		wr(RegResIdx, 16'h0064);
		rdc("res100 I", RegResI, 16'h0000);
		$display("test_sweep done");
	endtask

	// A short bulk load is dropped, a full one is taken
	task automatic test_bulk();
		wr(RegCtrl, 16'h0004);
		for (int i = 1; i < 100; i++)
			wr(RegPointVal, 16'(i * 16));
		rdc("load cnt", RegLoadCnt, 16'h0063);
		wr(RegCtrl, 16'h0008);
		go_stop("short load", 16'h04d2);
		wr(RegCtrl, 16'h0004);
		for (int i = 1; i <= 100; i++)
			wr(RegPointVal, 16'(i * 16));
		wr(RegCtrl, 16'h0008);
		go_stop("full load", 16'h0050);
		$display("test_bulk done");
	endtask

	////////////////////////////////////////////////////////////////////
	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Watchdog well past the roughly 1300 cycles of all tests
	initial begin
		repeat (20000) @(posedge clock);
		err_total++;
		finish_test();
	end

	initial begin
		repeat (4) @(posedge clock);
		reset <= 1'b0;
		repeat (2) @(posedge clock);
		test_idle();
		test_sweep();
		test_bulk();
		finish_test();
	end
endmodule // tb_ucs_sequencer

bind ucs_sequencer ucs_sequencer_asserts #(.TickLen(TickLen))
	u_ucs_sequencer_asserts (.clock, .reset, .regAddr, .regWrData,
	.regWrite, .regRead, .regRdData, .measIn, .remoteStandby,
	.resistanceMode, .setPoint, .dcInputOn, .userCurveMode);

`default_nettype wire
